// ==== bsrcfg_checker.sv ====
// Purpose: Port assertions for the boost regulator configuration bank.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Checks are held off during reset and the two edges after it.
`timescale 1ns/100ps
module bsrcfg_checker (
  input wire logic        REF_CLK,
  input wire logic        RESET,
  input wire logic [31:0] HRDATA,
  input wire logic        ALL_INDEPENDENT,
  input wire logic [5:0]  TARGET_CODE,
  input wire logic [15:0] TARGET_MV,
  input wire logic        ADAPTIVE_ACTIVE,
  input wire logic        JITTER_BYPASS,
  input wire logic [8:0]  JITTER_KHZ,
  input wire logic [2:0]  INT_GAIN,
  input wire logic [2:0]  PROP_GAIN,
  input wire logic [4:0]  RAMP_CYCLES,
  input wire logic [7:0]  OFF_TIME_NS,
  input wire logic [7:0]  BLANK_TIME_NS,
  input wire logic [4:0]  LLC_CURRENT_UA
);
  // Outputs still hold reset values when sampled at the first edge after release.
  logic rst_d, rst_dd;
  always_ff @(posedge REF_CLK) rst_d <= RESET;
  always_ff @(posedge REF_CLK) rst_dd <= rst_d;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET || rst_d || rst_dd);
  ////////////////////////////////////////
  property p_mv; TARGET_MV == 16'd16000 + 16'd500 * TARGET_CODE; endproperty
  a_mv: assert property (p_mv) else $error("target millivolts disagree with code");
  property p_jit; JITTER_BYPASS == (JITTER_KHZ == 9'd0) && JITTER_KHZ inside {0, 300, 60, 30}; endproperty
  a_jit: assert property (p_jit) else $error("jitter outputs inconsistent");
  property p_ig; INT_GAIN inside {[3'd1:3'd4]}; endproperty
  a_ig: assert property (p_ig) else $error("integral gain out of range");
  property p_pg; PROP_GAIN inside {[3'd1:3'd4]}; endproperty
  a_pg: assert property (p_pg) else $error("proportional gain out of range");
  property p_ramp; RAMP_CYCLES inside {1, 2, 3, 4, 5, 6, 8, 16}; endproperty
  a_ramp: assert property (p_ramp) else $error("ramp cycle count illegal");
  property p_off; OFF_TIME_NS inside {131, 68, 38, 24}; endproperty
  a_off: assert property (p_off) else $error("off time illegal");
  property p_blank; BLANK_TIME_NS inside {162, 88, 63, 40}; endproperty
  a_blank: assert property (p_blank) else $error("blanking time illegal");
  property p_llc; LLC_CURRENT_UA inside {5, 10, 15, 20}; endproperty
  a_llc: assert property (p_llc) else $error("light-load current illegal");
  property p_adap; ALL_INDEPENDENT [*3] |=> !ADAPTIVE_ACTIVE; endproperty
  a_adap: assert property (p_adap) else $error("adaptive active with all outputs independent");
  property p_rsv; HRDATA[31:8] == 24'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("read data upper bits not zero");
  c_adap: cover property (ADAPTIVE_ACTIVE);
  c_step: cover property (ADAPTIVE_ACTIVE && $changed(TARGET_CODE));
  c_ind: cover property (ALL_INDEPENDENT && !JITTER_BYPASS);
endmodule // bsrcfg_checker

bind bsrcfg_top bsrcfg_checker u_chk (.REF_CLK, .RESET, .HRDATA, .ALL_INDEPENDENT, .TARGET_CODE, .TARGET_MV,
  .ADAPTIVE_ACTIVE, .JITTER_BYPASS, .JITTER_KHZ, .INT_GAIN, .PROP_GAIN, .RAMP_CYCLES, .OFF_TIME_NS,
  .BLANK_TIME_NS, .LLC_CURRENT_UA);

// ==== bsrcfg_consts.vh ====
// Purpose: Constants for the boost regulator configuration bank.
// Assumes: Register indexes are word indexes; byte address is four times the index.
// Notes:   Included by every design file of the bank.
`ifndef BSRCFG_CONSTS_VH
`define BSRCFG_CONSTS_VH

// Register word indexes.
`define BSRC_IDX_START     8'h73
`define BSRC_IDX_LOOP      8'h74
`define BSRC_IDX_TIMING    8'h75
`define BSRC_IDX_CTRL      8'h80
`define BSRC_IDX_STATUS    8'h81

// Writable bit masks; clear bits are reserved.
`define BSRC_MASK_START    8'h3f
`define BSRC_MASK_LOOP     8'hff
`define BSRC_MASK_TIMING   8'hf7
`define BSRC_MASK_CTRL     8'h01

// Reset values.
`define BSRC_RST_START     8'h00
`define BSRC_RST_LOOP      8'h00
`define BSRC_RST_TIMING    8'h00
`define BSRC_RST_CTRL      8'h00

// Field positions.
`define BSRC_VCODE_MSB     5
`define BSRC_LLC_MSB       7
`define BSRC_LLC_LSB       6
`define BSRC_JIT_MSB       5
`define BSRC_JIT_LSB       4
`define BSRC_IGAIN_MSB     3
`define BSRC_IGAIN_LSB     2
`define BSRC_PGAIN_MSB     1
`define BSRC_PGAIN_LSB     0
`define BSRC_OFF_MSB       7
`define BSRC_OFF_LSB       6
`define BSRC_BLANK_MSB     5
`define BSRC_BLANK_LSB     4
`define BSRC_RAMP_MSB      2
`define BSRC_RAMP_LSB      0
`define BSRC_ADAP_BIT      0
`define BSRC_STAT_ACT_BIT  7

// Output voltage decode in millivolts.
`define BSRC_VBASE_MV      16'd16000
`define BSRC_VSTEP_MV      16'd500
`define BSRC_VCODE_MAX     6'h3f
`define BSRC_VCODE_MIN     6'h00

// Jitter filter corner frequencies in kHz.
`define BSRC_JIT_BYPASS    9'd0
`define BSRC_JIT_KHZ1      9'd300
`define BSRC_JIT_KHZ2      9'd60
`define BSRC_JIT_KHZ3      9'd30

// Switch off times and blanking times in ns.
`define BSRC_OFF_NS0       8'd131
`define BSRC_OFF_NS1       8'd68
`define BSRC_OFF_NS2       8'd38
`define BSRC_OFF_NS3       8'd24
`define BSRC_BLANK_NS0     8'd162
`define BSRC_BLANK_NS1     8'd88
`define BSRC_BLANK_NS2     8'd63
`define BSRC_BLANK_NS3     8'd40

// Light-load compensator current in uA.
`define BSRC_LLC_BASE_UA   5'd5
`define BSRC_LLC_STEP_UA   5'd5

// PWM cycles per target step, by rate code.
`define BSRC_RAMP_N0       5'd1
`define BSRC_RAMP_N1       5'd2
`define BSRC_RAMP_N2       5'd3
`define BSRC_RAMP_N3       5'd4
`define BSRC_RAMP_N4       5'd5
`define BSRC_RAMP_N5       5'd6
`define BSRC_RAMP_N6       5'd8
`define BSRC_RAMP_N7       5'd16

// Bus constants.
`define BSRC_HRESP_OKAY    1'b0
`define BSRC_HTRANS_ACT    1

`endif

// ==== bsrcfg_ramp.v ====
// Purpose: Paces adaptive target steps to at most one per N PWM cycles.
// Assumes: pwm_cycle is a one-cycle pulse per PWM period.
// Notes:   A request must be present on the PWM cycle pulse to be taken.
`timescale 1ns/100ps
`include "bsrcfg_consts.vh"

module bsrcfg_ramp (
  input  wire       clk,
  input  wire       rst,
  input  wire       pwm_cycle,
  input  wire [2:0] rate_sel,
  input  wire       req_up,
  input  wire       req_down,
  output reg        step_up,
  output reg        step_down,
  output wire [4:0] ramp_n
);

  reg  [4:0] cnt_reg;
  wire [4:0] elapsed;
  wire       req_one;

  function [4:0] rate_cycles;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    rate_cycles = `BSRC_RAMP_N0;
        3'h1:    rate_cycles = `BSRC_RAMP_N1;
        3'h2:    rate_cycles = `BSRC_RAMP_N2;
        3'h3:    rate_cycles = `BSRC_RAMP_N3;
        3'h4:    rate_cycles = `BSRC_RAMP_N4;
        3'h5:    rate_cycles = `BSRC_RAMP_N5;
        3'h6:    rate_cycles = `BSRC_RAMP_N6;
        default: rate_cycles = `BSRC_RAMP_N7;
      endcase
    end
  endfunction

  assign ramp_n  = rate_cycles(rate_sel);
  // Counting saturates at the longest spacing so it never wraps.
  assign elapsed = (cnt_reg >= `BSRC_RAMP_N7) ? `BSRC_RAMP_N7 : cnt_reg + 5'd1;
  assign req_one = req_up ^ req_down;

  //////////////////////////////////////////////////////////////////////////
  // step spacing gate
  always @(posedge clk) begin
    if (rst) begin
      cnt_reg   <= 5'd0;
      step_up   <= 1'b0;
      step_down <= 1'b0;
    end else begin
      step_up   <= 1'b0;
      step_down <= 1'b0;
      if (pwm_cycle) begin
        if (req_one && (elapsed >= ramp_n)) begin
          step_up   <= req_up;
          step_down <= req_down;
          cnt_reg   <= 5'd0;
        end else begin
          cnt_reg   <= elapsed;
        end
      end
    end
  end

endmodule // bsrcfg_ramp

// ==== bsrcfg_top.v ====
// Purpose: Boost regulator configuration bank with AHB-Lite register access.
// Assumes: One 25 MHz clock, synchronous active-high reset, word transfers only.
// Notes:   Zero wait states; every output comes from a flip-flop.
//          Decoded outputs lag their source register by one clock.
//          The byte address of a register is four times its word index.
//          The status word is read-only; writes to it are dropped.
//
// Summary of operation
// - Start code linear, 16 V plus 0.5 V steps.
// - Adaptive mode: start code only at start-up.
// - Adaptive off: target held at start code.
// - Jitter filter: bypass, 300, 60, 30 kHz.
// - Integral gain equals field plus one.
// - Proportional gain equals field plus one.
// - Target steps at most once per N cycles.
// - Off time 131, 68, 38, 24 ns.
// - Blanking time 162, 88, 63, 40 ns.
// - Light-load current 5 uA steps from 5 uA.
// - Adaptive needs enable bit, not all independent.
`timescale 1ns/100ps
`include "bsrcfg_consts.vh"

module bsrcfg_top (
  input  wire        REF_CLK,
  input  wire        RESET,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg         HREADYOUT,
  output reg  [31:0] HRDATA,
  output reg         HRESP,
  input  wire        PWM_CYCLE,
  input  wire        BOOST_START,
  input  wire        ADAPT_UP,
  input  wire        ADAPT_DOWN,
  input  wire        ALL_INDEPENDENT,
  output reg  [5:0]  TARGET_CODE,
  output reg  [15:0] TARGET_MV,
  output reg         ADAPTIVE_ACTIVE,
  output reg         JITTER_BYPASS,
  output reg  [8:0]  JITTER_KHZ,
  output reg  [2:0]  INT_GAIN,
  output reg  [2:0]  PROP_GAIN,
  output reg  [4:0]  RAMP_CYCLES,
  output reg  [7:0]  OFF_TIME_NS,
  output reg  [7:0]  BLANK_TIME_NS,
  output reg  [4:0]  LLC_CURRENT_UA
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations.
  reg  [7:0] start_reg;
  reg  [7:0] loop_reg;
  reg  [7:0] timing_reg;
  reg  [7:0] ctrl_reg;
  reg  [5:0] target_reg;
  reg  [5:0] target_next;
  reg        wr_pend_reg;
  reg  [7:0] wr_idx_reg;
  reg  [7:0] start_view;
  reg  [7:0] loop_view;
  reg  [7:0] timing_view;
  reg  [7:0] ctrl_view;
  reg  [7:0] rd_byte;
  wire       xfer;
  wire       addr_ok;
  wire [7:0] addr_idx;
  wire       adaptive_on;
  wire       step_up;
  wire       step_down;
  wire [4:0] ramp_n;
  wire       at_max;
  wire       at_min;
  wire [7:0] wr_byte;

  //////////////////////////////////////////////////////////////////////////
  // Functions.
  function [15:0] code_to_mv;
    input [5:0] code;
    begin
      code_to_mv = `BSRC_VBASE_MV + ({10'd0, code} * `BSRC_VSTEP_MV);
    end
  endfunction

  function [2:0] gain_of;
    input [1:0] field;
    begin
      gain_of = {1'b0, field} + 3'd1;
    end
  endfunction

  function [8:0] jitter_khz_of;
    input [1:0] field;
    begin
      case (field)
        2'h0:    jitter_khz_of = `BSRC_JIT_BYPASS;
        2'h1:    jitter_khz_of = `BSRC_JIT_KHZ1;
        2'h2:    jitter_khz_of = `BSRC_JIT_KHZ2;
        default: jitter_khz_of = `BSRC_JIT_KHZ3;
      endcase
    end
  endfunction

  function [7:0] off_ns_of;
    input [1:0] field;
    begin
      case (field)
        2'h0:    off_ns_of = `BSRC_OFF_NS0;
        2'h1:    off_ns_of = `BSRC_OFF_NS1;
        2'h2:    off_ns_of = `BSRC_OFF_NS2;
        default: off_ns_of = `BSRC_OFF_NS3;
      endcase
    end
  endfunction

  function [7:0] blank_ns_of;
    input [1:0] field;
    begin
      case (field)
        2'h0:    blank_ns_of = `BSRC_BLANK_NS0;
        2'h1:    blank_ns_of = `BSRC_BLANK_NS1;
        2'h2:    blank_ns_of = `BSRC_BLANK_NS2;
        default: blank_ns_of = `BSRC_BLANK_NS3;
      endcase
    end
  endfunction

  function [4:0] llc_ua_of;
    input [1:0] field;
    begin
      llc_ua_of = `BSRC_LLC_BASE_UA + ({3'd0, field} * `BSRC_LLC_STEP_UA);
    end
  endfunction

  // Writable bits of each register; reserved and unmapped bits stay clear.
  function [7:0] write_mask_of;
    input [7:0] idx;
    begin
      case (idx)
        `BSRC_IDX_START:  write_mask_of = `BSRC_MASK_START;
        `BSRC_IDX_LOOP:   write_mask_of = `BSRC_MASK_LOOP;
        `BSRC_IDX_TIMING: write_mask_of = `BSRC_MASK_TIMING;
        `BSRC_IDX_CTRL:   write_mask_of = `BSRC_MASK_CTRL;
        default:          write_mask_of = 8'h00;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase decode.
  assign xfer     = HSEL && HTRANS[`BSRC_HTRANS_ACT] && HREADY;
  assign addr_ok  = (HADDR[31:10] == 22'd0) && (HADDR[1:0] == 2'd0);
  assign addr_idx = HADDR[9:2];
  assign wr_byte  = HWDATA[7:0] & write_mask_of(wr_idx_reg);

  // A write lands in its data phase; a read in the same cycle sees it at once.
  // reserved bits masked
  always @* begin
    start_view  = start_reg;
    loop_view   = loop_reg;
    timing_view = timing_reg;
    ctrl_view   = ctrl_reg;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        `BSRC_IDX_START:  start_view  = wr_byte;
        `BSRC_IDX_LOOP:   loop_view   = wr_byte;
        `BSRC_IDX_TIMING: timing_view = wr_byte;
        `BSRC_IDX_CTRL:   ctrl_view   = wr_byte;
        default:          ctrl_view   = ctrl_reg;
      endcase
    end
  end

  // Unmapped and misaligned addresses read as zero.
  always @* begin
    rd_byte = 8'h00;
    if (addr_ok) begin
      case (addr_idx)
        `BSRC_IDX_START:  rd_byte = start_view;
        `BSRC_IDX_LOOP:   rd_byte = loop_view;
        `BSRC_IDX_TIMING: rd_byte = timing_view;
        `BSRC_IDX_CTRL:   rd_byte = ctrl_view;
        `BSRC_IDX_STATUS: rd_byte = {ADAPTIVE_ACTIVE, 1'b0, TARGET_CODE};
        default:          rd_byte = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus slave and register file.
  // The slave never stalls, so ready and response are rewritten as constants.
  always @(posedge REF_CLK) begin
    if (RESET) begin
      start_reg   <= `BSRC_RST_START;
      loop_reg    <= `BSRC_RST_LOOP;
      timing_reg  <= `BSRC_RST_TIMING;
      ctrl_reg    <= `BSRC_RST_CTRL;
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      HREADYOUT   <= 1'b1;
      HRESP       <= `BSRC_HRESP_OKAY;
      HRDATA      <= 32'h0000_0000;
    end else begin
      start_reg   <= start_view;
      loop_reg    <= loop_view;
      timing_reg  <= timing_view;
      ctrl_reg    <= ctrl_view;
      wr_pend_reg <= xfer && HWRITE && addr_ok;
      wr_idx_reg  <= addr_idx;
      HREADYOUT   <= 1'b1;
      HRESP       <= `BSRC_HRESP_OKAY;
      if (xfer && !HWRITE) begin
        HRDATA <= {24'h00_0000, rd_byte};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Adaptive target control.
  // adaptive qualification
  assign adaptive_on = ctrl_reg[`BSRC_ADAP_BIT] && !ALL_INDEPENDENT;
  // Saturation limits stop a paced step from wrapping the code.
  assign at_max      = (target_reg == `BSRC_VCODE_MAX);
  assign at_min      = (target_reg == `BSRC_VCODE_MIN);

  bsrcfg_ramp u_ramp (
    .clk       (REF_CLK),
    .rst       (RESET),
    .pwm_cycle (PWM_CYCLE),
    .rate_sel  (timing_reg[`BSRC_RAMP_MSB:`BSRC_RAMP_LSB]),
    .req_up    (adaptive_on && ADAPT_UP),
    .req_down  (adaptive_on && ADAPT_DOWN),
    .step_up   (step_up),
    .step_down (step_down),
    .ramp_n    (ramp_n)
  );

  // A restart outranks any paced step; the pacing counter survives rate changes.
  always @* begin
    target_next = target_reg;
    if (!adaptive_on) begin
      target_next = start_reg[`BSRC_VCODE_MSB:0];
    end else if (BOOST_START) begin
      target_next = start_reg[`BSRC_VCODE_MSB:0];
    end else if (step_up && !at_max) begin
      target_next = target_reg + 6'd1;
    end else if (step_down && !at_min) begin
      target_next = target_reg - 6'd1;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      target_reg <= `BSRC_VCODE_MIN;
    end else begin
      target_reg <= target_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered decoded outputs.
  // One clock of latency buys a flip-flop behind every decoded pin.
  always @(posedge REF_CLK) begin
    if (RESET) begin
      TARGET_CODE     <= 6'h00;
      TARGET_MV       <= 16'h0000;
      ADAPTIVE_ACTIVE <= 1'b0;
      JITTER_BYPASS   <= 1'b0;
      JITTER_KHZ      <= 9'h000;
      INT_GAIN        <= 3'h0;
      PROP_GAIN       <= 3'h0;
      RAMP_CYCLES     <= 5'h00;
      OFF_TIME_NS     <= 8'h00;
      BLANK_TIME_NS   <= 8'h00;
      LLC_CURRENT_UA  <= 5'h00;
    end else begin
      TARGET_CODE     <= target_reg;
      TARGET_MV       <= code_to_mv(target_reg);
      ADAPTIVE_ACTIVE <= adaptive_on;
      JITTER_BYPASS   <= (loop_reg[`BSRC_JIT_MSB:`BSRC_JIT_LSB] == 2'h0);
      JITTER_KHZ      <= jitter_khz_of(loop_reg[`BSRC_JIT_MSB:`BSRC_JIT_LSB]);
      INT_GAIN        <= gain_of(loop_reg[`BSRC_IGAIN_MSB:`BSRC_IGAIN_LSB]);
      PROP_GAIN       <= gain_of(loop_reg[`BSRC_PGAIN_MSB:`BSRC_PGAIN_LSB]);
      RAMP_CYCLES     <= ramp_n;
      OFF_TIME_NS     <= off_ns_of(timing_reg[`BSRC_OFF_MSB:`BSRC_OFF_LSB]);
      BLANK_TIME_NS   <= blank_ns_of(timing_reg[`BSRC_BLANK_MSB:`BSRC_BLANK_LSB]);
      LLC_CURRENT_UA  <= llc_ua_of(loop_reg[`BSRC_LLC_MSB:`BSRC_LLC_LSB]);
    end
  end

endmodule // bsrcfg_top

// ==== bsrcfg_top_tb.sv ====
// Purpose: Self-checking bench for the boost regulator configuration bank.
// Assumes: Zero-wait bus slave; byte address is four times the index.
// Notes:   Decoded outputs are compared a few cycles after each table row is written.
`timescale 1ns/100ps
`include "bsrcfg_consts.vh"
module bsrcfg_top_tb;
  typedef struct packed {
    logic [7:0] lp, tm, st;
    logic [4:0] llc;
    logic [8:0] khz;
    logic [2:0] ig, pg;
    logic [7:0] off, blk;
    logic [4:0] n;
    logic [15:0] mv;
  } bsrcfg_row_t;
  bsrcfg_row_t rows [8];
  logic [31:0] bad [3] = '{32'h5cc, 32'h1cd, 32'h3fc};
  logic REF_CLK = 0, RESET = 1, HSEL = 1, HWRITE = 0, PWM_CYCLE = 0, BOOST_START = 0;
  logic ADAPT_UP = 0, ADAPT_DOWN = 0, ALL_INDEPENDENT = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, x;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = 3'b010, INT_GAIN, PROP_GAIN;
  logic HREADYOUT, HRESP, ADAPTIVE_ACTIVE, JITTER_BYPASS;
  logic [5:0] TARGET_CODE;
  logic [15:0] TARGET_MV;
  logic [8:0] JITTER_KHZ;
  logic [4:0] RAMP_CYCLES, LLC_CURRENT_UA;
  logic [7:0] OFF_TIME_NS, BLANK_TIME_NS;
  wire HREADY = HREADYOUT;
  int mismatches = 0, check_count = 0, tmo = 0, k;
  bsrcfg_top dut (.REF_CLK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HREADYOUT,
    .HRDATA, .HRESP, .PWM_CYCLE, .BOOST_START, .ADAPT_UP, .ADAPT_DOWN, .ALL_INDEPENDENT, .TARGET_CODE,
    .TARGET_MV, .ADAPTIVE_ACTIVE, .JITTER_BYPASS, .JITTER_KHZ, .INT_GAIN, .PROP_GAIN, .RAMP_CYCLES,
    .OFF_TIME_NS, .BLANK_TIME_NS, .LLC_CURRENT_UA);
  always #20 REF_CLK = ~REF_CLK;
  ////////////////////////////////////////
  task automatic summarize;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    tmo++;
    if (tmo == 3000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  // Entered just after a rising edge; HSEL stays high, idle HTRANS ends a transfer.
  task automatic bus(input logic wr, input logic [31:0] ad, input logic [7:0] wd, output logic [31:0] rd);
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR <= ad;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    HTRANS <= 2'b00;
    HWDATA <= {24'h0, wd};
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    rd = HRDATA;
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, {22'h0, i, 2'b00}, d, x);
  endtask
  task automatic rchk(input string nm, input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, {22'h0, i, 2'b00}, 8'h00, x);
    chk(nm, {24'h0, e}, x);
  endtask
  task automatic pwm;
    PWM_CYCLE <= 1'b1;
    @(posedge REF_CLK);
    PWM_CYCLE <= 1'b0;
    cyc(4);
  endtask
  ////////////////////////////////////////
  initial begin
    rows[0] = '{8'h00, 8'h00, 8'h00, 5'd5, 9'd0, 3'd1, 3'd1, 8'd131, 8'd162, 5'd1, 16'd16000};
    rows[1] = '{8'h55, 8'h51, 8'h01, 5'd10, 9'd300, 3'd2, 3'd2, 8'd68, 8'd88, 5'd2, 16'd16500};
    rows[2] = '{8'haa, 8'ha2, 8'h02, 5'd15, 9'd60, 3'd3, 3'd3, 8'd38, 8'd63, 5'd3, 16'd17000};
    rows[3] = '{8'hff, 8'hf3, 8'h3f, 5'd20, 9'd30, 3'd4, 3'd4, 8'd24, 8'd40, 5'd4, 16'd47500};
    rows[4] = '{8'h1b, 8'h1c, 8'h04, 5'd5, 9'd300, 3'd3, 3'd4, 8'd131, 8'd88, 5'd5, 16'd18000};
    rows[5] = '{8'he4, 8'he5, 8'h14, 5'd20, 9'd60, 3'd2, 3'd1, 8'd24, 8'd63, 5'd6, 16'd26000};
    rows[6] = '{8'h00, 8'h0e, 8'h3e, 5'd5, 9'd0, 3'd1, 3'd1, 8'd131, 8'd162, 5'd8, 16'd47000};
    rows[7] = '{8'h00, 8'h07, 8'hc1, 5'd5, 9'd0, 3'd1, 3'd1, 8'd131, 8'd162, 5'd16, 16'd16500};
    cyc(4);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    foreach (rows[i]) begin
      wreg(`BSRC_IDX_LOOP, rows[i].lp);
      wreg(`BSRC_IDX_TIMING, rows[i].tm);
      wreg(`BSRC_IDX_START, rows[i].st);
      cyc(4);
      rchk("loop", `BSRC_IDX_LOOP, rows[i].lp);
      rchk("timing", `BSRC_IDX_TIMING, rows[i].tm & 8'hf7);
      rchk("start", `BSRC_IDX_START, rows[i].st & 8'h3f);
      chk("llc", rows[i].llc, LLC_CURRENT_UA);
      chk("jitter", rows[i].khz, JITTER_KHZ);
      chk("bypass", rows[i].khz == 0, JITTER_BYPASS);
      chk("igain", rows[i].ig, INT_GAIN);
      chk("pgain", rows[i].pg, PROP_GAIN);
      chk("off", rows[i].off, OFF_TIME_NS);
      chk("blank", rows[i].blk, BLANK_TIME_NS);
      chk("ramp", rows[i].n, RAMP_CYCLES);
      chk("mv", rows[i].mv, TARGET_MV);
      chk("code", rows[i].st & 8'h3f, TARGET_CODE);
    end
    wreg(`BSRC_IDX_TIMING, 8'h02);
    wreg(`BSRC_IDX_START, 8'h0a);
    wreg(`BSRC_IDX_CTRL, 8'h01);
    cyc(3);
    chk("active", 1, ADAPTIVE_ACTIVE);
    rchk("status", `BSRC_IDX_STATUS, 8'h8a);
    ADAPT_UP <= 1'b1;
    for (k = 1; k <= 6; k++) begin
      pwm();
      chk("step up", 10 + k / 3, TARGET_CODE);
    end
    wreg(`BSRC_IDX_START, 8'h14);
    cyc(3);
    chk("held", 12, TARGET_CODE);
    BOOST_START <= 1'b1;
    @(posedge REF_CLK);
    BOOST_START <= 1'b0;
    ADAPT_UP <= 1'b0;
    ADAPT_DOWN <= 1'b1;
    cyc(3);
    chk("reload", 20, TARGET_CODE);
    for (k = 1; k <= 3; k++) begin
      pwm();
      chk("step down", 20 - k / 3, TARGET_CODE);
    end
    ADAPT_UP <= 1'b1;
    repeat (3) pwm();
    chk("both held", 19, TARGET_CODE);
    ADAPT_UP <= 1'b0;
    ADAPT_DOWN <= 1'b0;
    ALL_INDEPENDENT <= 1'b1;
    cyc(4);
    chk("forced off", 0, ADAPTIVE_ACTIVE);
    chk("fixed", 20, TARGET_CODE);
    ALL_INDEPENDENT <= 1'b0;
    wreg(`BSRC_IDX_STATUS, 8'hff);
    wreg(`BSRC_IDX_CTRL, 8'hfe);
    cyc(3);
    rchk("ctrl", `BSRC_IDX_CTRL, 8'h00);
    rchk("status ro", `BSRC_IDX_STATUS, 8'h14);
    foreach (bad[i]) begin
      bus(1'b1, bad[i], 8'h2a, x);
      bus(1'b0, bad[i], 8'h00, x);
      chk("unmapped", 0, x);
      chk("hresp", `BSRC_HRESP_OKAY, HRESP);
      chk("hreadyout", 1, HREADYOUT);
    end
    rchk("start kept", `BSRC_IDX_START, 8'h14);
    RESET <= 1'b1;
    cyc(4);
    RESET <= 1'b0;
    cyc(2);
    rchk("start reset", `BSRC_IDX_START, 8'h00);
    chk("mv reset", 16000, TARGET_MV);
    chk("ramp reset", 1, RAMP_CYCLES);
    summarize();
  end
endmodule // bsrcfg_top_tb
